// >>> hdl/int_seq_regs.vh
// Constants for the interrupt recognition and sequencing unit
`ifndef INT_SEQ_REGS_VH
`define INT_SEQ_REGS_VH
`define NUM_SRC        20
`define SRC_W          5
`define VEC_BASE       16'hFFDC
`define VEC_TRAP       16'hFFFC
`define VEC_RESET      16'hFFFE
`define SP_RESET       16'h00FF
`define CCR_I_BIT      3
`define CCR_RESET      8'h08
`endif

// >>> hdl/int_priority_pick.v
// Fixed-priority picker over qualified interrupt requests
`timescale 1ns/1ps
module int_priority_pick (
   // Requests, bit 0 is the highest priority
   input  wire [19:0] qualified,
   // Result
   output reg         any,
   output reg  [4:0]  index
);
   integer i;
   always @* begin
      any   = 1'b0;
      index = 5'h00;
      // Scan downward so the lowest set bit wins
      for (i = 19; i >= 0; i = i - 1) begin
         if (qualified[i]) begin
            any   = 1'b1;
            index = i[4:0];
         end
      end
   end
endmodule

// >>> hdl/int_sequencer.v
// Interrupt recognition, stacking and return sequencer
//
// Summary of operation
// - A request never interrupts the instruction in progress; it waits.
// - All pending request lines are evaluated at every instruction boundary.
// - Request entry starts only with mask flag clear and source enable set.
// - Nothing qualifying: the next instruction runs with no added cycles.
// - Among qualifying requests the highest fixed priority goes first.
// - A request that qualifies under the restored mask at return is serviced before the return address runs.
// - Every return prefetches the opcode at the return address.
// - The upper index byte is never pushed during entry.
// - Reset outranks every interrupt and is never arbitrated.
// - The trap ignores the mask flag and stacks the current counter.
`timescale 1ns/1ps
`include "int_seq_regs.vh"
module int_sequencer (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Peripheral requests and their enables
   input  wire [19:0] irq_req,
   input  wire [19:0] irq_en,
   // CPU core handshake
   input  wire        insn_done,
   input  wire        return_from_service_op,
   input  wire        software_trap_op,
   input  wire [15:0] cpu_pc,
   input  wire [7:0]  cpu_a,
   input  wire [7:0]  cpu_x,
   input  wire [7:0]  cpu_ccr,
   input  wire [15:0] cpu_sp,
   // Memory port
   output reg  [15:0] mem_addr,
   output reg  [7:0]  mem_wdata,
   output reg         mem_we,
   output reg         mem_re,
   input  wire [7:0]  mem_rdata,
   // Results to the core
   output reg         cpu_hold,
   output wire        next_insn_go,
   output reg         load_state,
   output reg  [15:0] new_pc,
   output reg  [7:0]  new_a,
   output reg  [7:0]  new_x,
   output reg  [7:0]  new_ccr,
   output reg  [15:0] new_sp,
   output reg         irq_ack,
   output reg  [4:0]  irq_ack_src,
   output reg         prefetch_re,
   output reg  [15:0] prefetch_addr
);
   // ********************************************
   // States
   // ********************************************
   localparam S_RUN  = 4'h0;
   localparam S_PCL  = 4'h1;
   localparam S_PCH  = 4'h2;
   localparam S_PX   = 4'h3;
   localparam S_PA   = 4'h4;
   localparam S_PCC  = 4'h5;
   localparam S_VH   = 4'h6;
   localparam S_VL   = 4'h7;
   localparam S_DONE = 4'h8;
   localparam S_RCC  = 4'h9;
   localparam S_RA   = 4'hA;
   localparam S_RX   = 4'hB;
   localparam S_RPH  = 4'hC;
   localparam S_RPL  = 4'hD;
   localparam S_HI   = 4'hE;

   reg  [3:0]  state;
   reg  [15:0] sp;
   reg  [15:0] ret_pc;
   reg  [15:0] vec_addr;
   reg  [7:0]  ccr;
   reg  [7:0]  acc;
   reg  [7:0]  idx;
   reg  [7:0]  hi_byte;
   reg         in_return;

   wire        any;
   wire [4:0]  pick;

   // ********************************************
   // Arbitration
   // ********************************************
   // Mask flag does not gate the trap; enables gate each source
   int_priority_pick u_pick (
      .qualified (irq_req & irq_en),
      .any       (any),
      .index     (pick)
   );

   function [15:0] vec_of;
      input [4:0] src;
      begin
         vec_of = `VEC_BASE - {10'h000, src, 1'b0};
      end
   endfunction

   // Sampled only at the boundary, so no instruction is cut short
   wire boundary  = insn_done && (state == S_RUN);
   wire take_irq  = any && !cpu_ccr[`CCR_I_BIT];
   // No qualifier: core moves on that same cycle
   assign next_insn_go = boundary && !software_trap_op &&
                         !return_from_service_op && !take_irq;

   always @(posedge clk) begin
      load_state  <= 1'b0;
      irq_ack     <= 1'b0;
      prefetch_re <= 1'b0;
      mem_we      <= 1'b0;
      mem_re      <= 1'b0;
      if (!rst_n) begin
         // Reset pre-empts any sequence in flight
         state       <= S_RUN;
         sp          <= `SP_RESET;
         ret_pc      <= 16'h0000;
         vec_addr    <= `VEC_RESET;
         ccr         <= `CCR_RESET;
         acc         <= 8'h00;
         idx         <= 8'h00;
         hi_byte     <= 8'h00;
         in_return   <= 1'b0;
         cpu_hold    <= 1'b0;
         mem_addr    <= 16'h0000;
         mem_wdata   <= 8'h00;
         new_pc      <= 16'h0000;
         new_a       <= 8'h00;
         new_x       <= 8'h00;
         new_ccr     <= `CCR_RESET;
         new_sp      <= `SP_RESET;
         irq_ack_src <= 5'h00;
         prefetch_addr <= 16'h0000;
      end else begin
         case (state)
            S_RUN: begin
               if (boundary) begin
                  sp  <= cpu_sp;
                  ccr <= cpu_ccr;
                  acc <= cpu_a;
                  idx <= cpu_x;
                  if (return_from_service_op) begin
                     cpu_hold  <= 1'b1;
                     in_return <= 1'b1;
                     state     <= S_RCC;
                  end else if (software_trap_op) begin
                     cpu_hold <= 1'b1;
                     ret_pc   <= cpu_pc;
                     vec_addr <= `VEC_TRAP;
                     state    <= S_PCL;
                  end else if (take_irq) begin
                     cpu_hold    <= 1'b1;
                     ret_pc      <= cpu_pc - 16'h0001;
                     vec_addr    <= vec_of(pick);
                     irq_ack     <= 1'b1;
                     irq_ack_src <= pick;
                     state       <= S_PCL;
                  end
               end
            end
            // Push PC low, PC high, X, A, CCR at descending addresses
            S_PCL: begin
               mem_addr  <= sp;
               mem_wdata <= ret_pc[7:0];
               mem_we    <= 1'b1;
               sp        <= sp - 16'h0001;
               state     <= S_PCH;
            end
            S_PCH: begin
               mem_addr  <= sp;
               mem_wdata <= ret_pc[15:8];
               mem_we    <= 1'b1;
               sp        <= sp - 16'h0001;
               state     <= S_PX;
            end
            // Upper index byte deliberately skipped
            S_PX: begin
               mem_addr  <= sp;
               mem_wdata <= idx;
               mem_we    <= 1'b1;
               sp        <= sp - 16'h0001;
               state     <= S_PA;
            end
            S_PA: begin
               mem_addr  <= sp;
               mem_wdata <= acc;
               mem_we    <= 1'b1;
               sp        <= sp - 16'h0001;
               state     <= S_PCC;
            end
            S_PCC: begin
               mem_addr  <= sp;
               mem_wdata <= ccr;
               mem_we    <= 1'b1;
               sp        <= sp - 16'h0001;
               ccr[`CCR_I_BIT] <= 1'b1;
               state     <= S_VH;
            end
            // Read data arrives two edges after each read request
            S_VH: begin
               mem_addr <= vec_addr;
               mem_re   <= 1'b1;
               state    <= S_VL;
            end
            S_VL: begin
               mem_addr <= vec_addr + 16'h0001;
               mem_re   <= 1'b1;
               state    <= S_HI;
            end
            // High byte of the vector or of the popped counter
            S_HI: begin
               hi_byte <= mem_rdata;
               state   <= S_DONE;
            end
            S_DONE: begin
               // Prefetch happens even if a request follows
               if (in_return) begin
                  prefetch_re   <= 1'b1;
                  prefetch_addr <= {hi_byte, mem_rdata};
               end
               in_return <= 1'b0;
               // Restored mask decides; pending request re-enters
               if (in_return && any && !ccr[`CCR_I_BIT]) begin
                  ret_pc      <= {hi_byte, mem_rdata};
                  vec_addr    <= vec_of(pick);
                  irq_ack     <= 1'b1;
                  irq_ack_src <= pick;
                  state       <= S_PCL;
               end else begin
                  new_pc     <= {hi_byte, mem_rdata};
                  new_a      <= acc;
                  new_x      <= idx;
                  new_ccr    <= ccr;
                  new_sp     <= sp;
                  load_state <= 1'b1;
                  cpu_hold   <= 1'b0;
                  state      <= S_RUN;
               end
            end
            // Pop CCR, A, X, PC high, PC low at ascending addresses
            S_RCC: begin
               mem_addr <= sp + 16'h0001;
               mem_re   <= 1'b1;
               sp       <= sp + 16'h0001;
               state    <= S_RA;
            end
            S_RA: begin
               mem_addr <= sp + 16'h0001;
               mem_re   <= 1'b1;
               sp       <= sp + 16'h0001;
               state    <= S_RX;
            end
            S_RX: begin
               ccr      <= mem_rdata;
               mem_addr <= sp + 16'h0001;
               mem_re   <= 1'b1;
               sp       <= sp + 16'h0001;
               state    <= S_RPH;
            end
            S_RPH: begin
               acc      <= mem_rdata;
               mem_addr <= sp + 16'h0001;
               mem_re   <= 1'b1;
               sp       <= sp + 16'h0001;
               state    <= S_RPL;
            end
            S_RPL: begin
               idx      <= mem_rdata;
               mem_addr <= sp + 16'h0001;
               mem_re   <= 1'b1;
               sp       <= sp + 16'h0001;
               state    <= S_HI;
            end
            default: begin
               state    <= S_RUN;
               cpu_hold <= 1'b0;
            end
         endcase
      end
   end
endmodule

// >>> verif/int_seq_chk.sv
// Port-level assertions for the interrupt sequencer
`timescale 1ns/1ps
module int_seq_chk (
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Requests and core state
   input wire [19:0] irq_req,
   input wire [19:0] irq_en,
   input wire        insn_done,
   input wire        return_from_service_op,
   input wire        software_trap_op,
   input wire [7:0]  cpu_ccr,
   // Sequencer results
   input wire        mem_we,
   input wire        mem_re,
   input wire        cpu_hold,
   input wire        next_insn_go,
   input wire        load_state,
   input wire [7:0]  new_ccr,
   input wire        irq_ack,
   input wire [4:0]  irq_ack_src,
   input wire        prefetch_re
);
   wire       bnd = insn_done && !cpu_hold;
   wire       plain = bnd && !return_from_service_op && !software_trap_op;
   wire       qual = |(irq_req & irq_en) && !cpu_ccr[3];
   reg  [4:0] top;
   integer    i;

   // Lowest set index wins, so scan from the top down
   always @* begin
      top = 5'h00;
      for (i = 19; i >= 0; i = i - 1)
         if (irq_req[i] && irq_en[i])
            top = i[4:0];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence push_s; mem_we [*5]; endsequence
   sequence fetch_s; mem_re [*2] ##2 load_state; endsequence

   ack_on_qual_a: assert property (
      plain && qual |=> irq_ack && cpu_hold)
      else $error("qualified request not taken");
   fall_through_a: assert property (
      plain && !qual |-> next_insn_go ##1 !irq_ack)
      else $error("unqualified boundary added cycles");
   pick_top_a: assert property (irq_ack && $past(plain && qual)
      |-> irq_ack_src == $past(top)) else $error("wrong source picked");
   entry_seq_a: assert property (irq_ack |=> push_s ##1 fetch_s)
      else $error("entry sequence broken");
   mask_set_a: assert property (load_state && $past(irq_ack, 9)
      |-> new_ccr[3]) else $error("mask not set on entry");
   trap_entry_a: assert property (bnd && software_trap_op
      && !return_from_service_op |=> cpu_hold ##9 load_state)
      else $error("trap not entered");
   hold_no_go_a: assert property (cpu_hold |-> !next_insn_go)
      else $error("next instruction during sequence");
   ret_prefetch_a: assert property (bnd && return_from_service_op
      |-> ##[1:12] prefetch_re) else $error("no return prefetch");
endmodule

bind int_sequencer int_seq_chk u_chk (.clk(clk), .rst_n(rst_n),
   .irq_req(irq_req), .irq_en(irq_en), .insn_done(insn_done),
   .return_from_service_op(return_from_service_op),
   .software_trap_op(software_trap_op), .cpu_ccr(cpu_ccr),
   .mem_we(mem_we), .mem_re(mem_re), .cpu_hold(cpu_hold),
   .next_insn_go(next_insn_go), .load_state(load_state),
   .new_ccr(new_ccr), .irq_ack(irq_ack), .irq_ack_src(irq_ack_src),
   .prefetch_re(prefetch_re));

// >>> verif/int_mem_model.sv
// Memory model holding the stack area and vector table
`timescale 1ns/1ps
module int_mem_model (
   // Clock
   input wire        clk,
   // Memory port
   input wire [15:0] mem_addr,
   input wire [7:0]  mem_wdata,
   input wire        mem_we,
   input wire        mem_re,
   output reg [7:0]  mem_rdata
);
   reg [7:0] mem [0:65535];

   initial mem_rdata = 8'h00;
   always @(posedge clk) begin
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
      // Stale data inverted so a late sample cannot pass
      mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
   end
endmodule

// >>> verif/test_hw_interrupt_recognition.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module test_hw_interrupt_recognition;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [19:0] irq_req = 20'h00000;
   reg  [19:0] irq_en = 20'h00000;
   reg         insn_done = 1'b0;
   reg         ret = 1'b0;
   reg         trap = 1'b0;
   reg  [15:0] cpu_pc = 16'h0000;
   reg  [7:0]  cpu_a = 8'h00;
   reg  [7:0]  cpu_x = 8'h00;
   reg  [7:0]  cpu_ccr = 8'h08;
   reg  [15:0] cpu_sp = 16'h00F0;
   reg  [19:0] rq, en;
   reg  [7:0]  f;
   wire [15:0] mem_addr, new_pc, new_sp, prefetch_addr;
   wire [7:0]  mem_wdata, mem_rdata, new_a, new_x, new_ccr;
   wire        mem_we, mem_re, cpu_hold, next_insn_go, load_state;
   wire        irq_ack, prefetch_re;
   wire [4:0]  irq_ack_src;
   integer     n_mismatch = 0;
   integer     cmp_count = 0;
   integer     seed = 32'hCD4D;
   integer     k, w;
   reg  [15:0] exp_q [$];

   int_sequencer u_dut (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
      .irq_en(irq_en), .insn_done(insn_done),
      .return_from_service_op(ret), .software_trap_op(trap),
      .cpu_pc(cpu_pc), .cpu_a(cpu_a), .cpu_x(cpu_x), .cpu_ccr(cpu_ccr),
      .cpu_sp(cpu_sp), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
      .cpu_hold(cpu_hold), .next_insn_go(next_insn_go),
      .load_state(load_state), .new_pc(new_pc), .new_a(new_a),
      .new_x(new_x), .new_ccr(new_ccr), .new_sp(new_sp),
      .irq_ack(irq_ack), .irq_ack_src(irq_ack_src),
      .prefetch_re(prefetch_re), .prefetch_addr(prefetch_addr));
   int_mem_model u_mem (.clk(clk), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata));

   always #4 clk = ~clk;

   task chk(input string nm, input [15:0] ex, input [15:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== ex) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            n_mismatch = n_mismatch + 1;
         end
      end
   endtask

   task end_sim;
      begin
         if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   function [7:0] first(input [19:0] q);
      integer j;
      begin
         first = 8'h14;
         for (j = 19; j >= 0; j = j - 1)
            if (q[j])
               first = j[7:0];
      end
   endfunction

   // One instruction boundary; go marks an expected sequence
   task step(input r, t, input [19:0] a, b, input [7:0] cc,
             input [15:0] pc, sp, input go, input [15:0] ex);
      begin
         @(posedge clk);
         #1 {ret, trap, irq_req, irq_en, cpu_ccr} = {r, t, a, b, cc};
         {cpu_pc, cpu_sp, insn_done} = {pc, sp, 1'b1};
         cpu_a = $random(seed);
         // Core keeps its own upper index byte; only the low byte stacks
         cpu_x = $random(seed);
         if (go)
            exp_q.push_back(ex);
         #2 chk("next_insn_go", {15'h0000, !go}, next_insn_go);
         @(posedge clk);
         #1 insn_done = 1'b0;
         w = 0;
         while (cpu_hold !== 1'b0 && w < 40) begin
            @(posedge clk);
            #1 w = w + 1;
         end
         if (w == 40)
            chk("cpu_hold", 16'h0000, 16'h0001);
      end
   endtask

   // Results in arrival order
   always @(posedge clk)
      if (load_state === 1'b1) begin
         if (exp_q.size() == 0)
            chk("spare load_state", 16'h0000, 16'h0001);
         else
            chk("new_pc", exp_q.pop_front(), new_pc);
         chk("new_ccr mask", 16'h0001, {15'h0000, new_ccr[3]});
      end

   // Both returns in the scenarios go back to the same address
   always @(posedge clk)
      if (prefetch_re === 1'b1)
         chk("prefetch_addr", 16'h1234, prefetch_addr);

   initial begin
      #20000 n_mismatch = n_mismatch + 1;
      end_sim;
   end

   initial begin
      for (k = 0; k < 20; k = k + 1) begin
         u_mem.mem[16'hFFDC - 2 * k] = 8'h80 + k;
         u_mem.mem[16'hFFDD - 2 * k] = k;
      end
      u_mem.mem[16'hFFFC] = 8'hC0;
      u_mem.mem[16'hFFFD] = 8'h0C;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("new_ccr", 16'h0008, new_ccr);
      chk("new_sp", 16'h00FF, new_sp);
      step(0, 0, 20'hFFFFF, 20'hFFFFF, 8'h08, 16'h0100, 16'h00F0, 0, 0);
      step(0, 0, 20'hFFFFF, 20'h00000, 8'h00, 16'h0100, 16'h00F0, 0, 0);
      for (k = 0; k < 30; k = k + 1) begin
         rq = $random(seed);
         en = $random(seed);
         f = first(rq & en);
         step(0, 0, rq, en, 8'h00, 16'h0200, 16'h00F0, f < 8'h14,
              {8'h80 + f, f});
      end
      step(0, 1, 20'h00000, 20'h00000, 8'h08, 16'h1234, 16'h00F0, 1,
           16'hC00C);
      step(1, 0, 20'h00100, 20'h00100, 8'h08, 16'h3000, 16'h00EB, 1,
           16'h1234);
      step(0, 1, 20'h00000, 20'h00000, 8'h00, 16'h1234, 16'h00F0, 1,
           16'hC00C);
      step(1, 0, 20'h00100, 20'h00100, 8'h08, 16'h3000, 16'h00EB, 1,
           16'h8808);
      // Reset during a trap sequence abandons it at once
      @(posedge clk);
      #1 {ret, trap, insn_done} = 3'b011;
      @(posedge clk);
      #1 insn_done = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b0;
      @(posedge clk);
      #1 rst_n = 1'b1;
      trap = 1'b0;
      chk("cpu_hold", 16'h0000, {15'h0000, cpu_hold});
      chk("new_sp", 16'h00FF, new_sp);
      repeat (5) @(posedge clk);
      chk("queue", 16'h0000, 16'(exp_q.size()));
      end_sim;
   end
endmodule
